// [src/pll_route_pkg.sv]
// Register map, field layout and reset values for PLL source routing control
package pll_route_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_POWER_POL = 10'h010;
    localparam logic [9:0] IDX_ANTIBACKLASH = 10'h017;
    localparam logic [9:0] IDX_VCO_CAL = 10'h018;
    localparam logic [9:0] IDX_POST_DIV = 10'h1e0;
    localparam logic [9:0] IDX_ROUTING = 10'h1e1;
    localparam logic [9:0] IDX_COMMIT = 10'h232;
    localparam logic [9:0] IDX_STATUS = 10'h233;
    // Field positions
    localparam int POWER_LSB = 0;
    localparam int POLARITY_BIT = 7;
    localparam int ABL_LSB = 0;
    localparam int CAL_BIT = 0;
    localparam int POST_DIV_LSB = 0;
    localparam int BYPASS_BIT = 0;
    localparam int SRC_VCO_BIT = 1;
    // Field values and reset values
    localparam logic [1:0] POWER_RUN = 2'h0;
    localparam logic [1:0] POWER_ASYNC_PD = 2'h1;
    localparam logic [1:0] POWER_RST = 2'h1;
    localparam logic POLARITY_RST = 1'h0;
    localparam logic [1:0] ABL_RST = 2'h0;
    localparam logic CAL_RST = 1'h0;
    localparam logic [2:0] POST_DIV_RST = 3'h2;
    localparam logic BYPASS_RST = 1'h0;
    localparam logic SRC_VCO_RST = 1'h0;
    localparam logic [7:0] COMMIT_CODE = 8'h01;
    // Antibacklash pulse length is this many clock cycles plus one at field value zero
    localparam int ABL_BASE_CYCLES = 1;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [src/pfd_ctrl_if.sv]
// Control and result signals between the register block and the phase detector
`timescale 1ns/1ps
interface pfd_ctrl_if;
    logic enable;
    logic invert;
    logic [1:0] abl_width;
    logic up;
    logic down;
    modport ctrl (output enable, output invert, output abl_width, input up, input down);
    modport det (input enable, input invert, input abl_width, output up, output down);
endinterface

// [src/phase_freq_detector.sv]
// Phase frequency detector with programmable antibacklash overlap
`timescale 1ns/1ps
module phase_freq_detector
    import pll_route_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Divider outputs from the analog side
    input wire logic ref_div_in,
    input wire logic fb_div_in,
    // Control and result
    pfd_ctrl_if.det pfd
);
    logic [1:0] ref_sync_q;
    logic [1:0] fb_sync_q;
    logic ref_last_q;
    logic fb_last_q;
    logic up_q;
    logic down_q;
    logic [2:0] abl_cnt_q;
    logic ref_edge;
    logic fb_edge;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_sync_q <= 2'h0;
            fb_sync_q <= 2'h0;
            ref_last_q <= 1'h0;
            fb_last_q <= 1'h0;
        end else begin
            ref_sync_q <= {ref_sync_q[0], ref_div_in};
            fb_sync_q <= {fb_sync_q[0], fb_div_in};
            ref_last_q <= ref_sync_q[1];
            fb_last_q <= fb_sync_q[1];
        end
    end

    assign ref_edge = ref_sync_q[1] & ~ref_last_q;
    assign fb_edge = fb_sync_q[1] & ~fb_last_q;

    // Reference edge pumps up, feedback edge pumps down; both high for the
    // antibacklash time, then both cleared so there is no dead zone
    always_ff @(posedge aclk) begin
        if (!aresetn || !pfd.enable) begin
            up_q <= 1'h0;
            down_q <= 1'h0;
            abl_cnt_q <= 3'h0;
        end else if (up_q && down_q) begin
            if (abl_cnt_q >= 3'(ABL_BASE_CYCLES) + {1'b0, pfd.abl_width}) begin
                up_q <= 1'h0;
                down_q <= 1'h0;
                abl_cnt_q <= 3'h0;
            end else begin
                abl_cnt_q <= abl_cnt_q + 3'h1;
            end
        end else begin
            if (ref_edge) begin
                up_q <= 1'h1;
            end
            if (fb_edge) begin
                down_q <= 1'h1;
            end
        end
    end

    // Negative polarity swaps the pump sense
    assign pfd.up = pfd.invert ? down_q : up_q;
    assign pfd.down = pfd.invert ? up_q : down_q;
endmodule

// [src/pll_clock_source_routing.sv]
// PLL power, clock source routing and VCO calibration control with AXI4-Lite registers
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module pll_clock_source_routing
    import pll_route_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Divider outputs into the phase detector
    input wire logic ref_div_in,
    input wire logic fb_div_in,
    // Analog loop and distribution controls
    output logic pll_run,
    output logic pll_async_pd,
    output logic [2:0] post_div_ratio,
    output logic div_bypass,
    output logic src_vco,
    output logic pfd_negative,
    output logic [1:0] abl_width,
    output logic vco_cal_start,
    output logic cp_up,
    output logic cp_down
);
    // Staged copies
    logic [1:0] stg_power_q;
    logic stg_pol_q;
    logic [1:0] stg_abl_q;
    logic stg_cal_q;
    logic [2:0] stg_div_q;
    logic stg_bypass_q;
    logic stg_src_q;
    // Active copies
    logic [1:0] act_power_q;
    logic act_pol_q;
    logic [1:0] act_abl_q;
    logic act_cal_q;
    logic [2:0] act_div_q;
    logic act_bypass_q;
    logic act_src_q;
    // Bus state
    logic [11:0] aw_addr_q;
    logic aw_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_held_q;
    logic aw_held_d;
    logic w_held_d;
    logic bvalid_d;
    logic wr_fire;
    logic wr_lane0;
    logic [9:0] wr_idx;
    logic commit;
    pfd_ctrl_if pfd ();

    // Register index from a byte address
    function automatic logic [9:0] word_index(input logic [11:0] addr);
        return addr[11:2];
    endfunction

    function automatic logic is_mapped(input logic [9:0] idx);
        return idx == IDX_POWER_POL || idx == IDX_ANTIBACKLASH || idx == IDX_VCO_CAL ||
            idx == IDX_POST_DIV || idx == IDX_ROUTING || idx == IDX_COMMIT ||
            idx == IDX_STATUS;
    endfunction

    // Post-divider code to ratio; 0 marks an unsupported code
    function automatic logic [2:0] ratio_of(input logic [2:0] code);
        case (code)
            3'h0: return 3'h2;
            3'h1: return 3'h3;
            3'h2: return 3'h4;
            3'h3: return 3'h5;
            3'h4: return 3'h6;
            default: return 3'h0;
        endcase
    endfunction

    // Write channel: address and data accepted in either order
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_idx = word_index(aw_addr_q);
    assign wr_lane0 = wr_fire && w_strb_q[0];
    assign commit = wr_lane0 && wr_idx == IDX_COMMIT && w_data_q[7:0] == COMMIT_CODE;

    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        bvalid_d = s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'h1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d = 1'h1;
        end
        if (wr_fire) begin
            aw_held_d = 1'h0;
            w_held_d = 1'h0;
            bvalid_d = 1'h1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'h0;
            w_held_q <= 1'h0;
            aw_addr_q <= 12'h0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'h0;
            s_axi_wready <= 1'h0;
            s_axi_bvalid <= 1'h0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            s_axi_awready <= !aw_held_d && !bvalid_d;
            s_axi_wready <= !w_held_d && !bvalid_d;
            s_axi_bvalid <= bvalid_d;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bresp <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Staging copies take writes; nothing reaches the loop until commit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stg_power_q <= POWER_RST;
            stg_pol_q <= POLARITY_RST;
            stg_abl_q <= ABL_RST;
            stg_cal_q <= CAL_RST;
            stg_div_q <= POST_DIV_RST;
            stg_bypass_q <= BYPASS_RST;
            stg_src_q <= SRC_VCO_RST;
        end else if (wr_lane0) begin
            case (wr_idx)
                IDX_POWER_POL: begin
                    stg_power_q <= w_data_q[POWER_LSB +: 2];
                    stg_pol_q <= w_data_q[POLARITY_BIT];
                end
                IDX_ANTIBACKLASH: stg_abl_q <= w_data_q[ABL_LSB +: 2];
                IDX_VCO_CAL: stg_cal_q <= w_data_q[CAL_BIT];
                IDX_POST_DIV: stg_div_q <= w_data_q[POST_DIV_LSB +: 3];
                IDX_ROUTING: begin
                    stg_bypass_q <= w_data_q[BYPASS_BIT];
                    stg_src_q <= w_data_q[SRC_VCO_BIT];
                end
                default: ;
            endcase
        end
    end

    // All active copies load together on commit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_power_q <= POWER_RST;
            act_pol_q <= POLARITY_RST;
            act_abl_q <= ABL_RST;
            act_cal_q <= CAL_RST;
            act_div_q <= POST_DIV_RST;
            act_bypass_q <= BYPASS_RST;
            act_src_q <= SRC_VCO_RST;
        end else if (commit) begin
            act_power_q <= stg_power_q;
            act_pol_q <= stg_pol_q;
            act_abl_q <= stg_abl_q;
            act_cal_q <= stg_cal_q;
            act_div_q <= stg_div_q;
            act_bypass_q <= stg_bypass_q;
            act_src_q <= stg_src_q;
        end
    end

    // Loop and routing outputs follow the active copies
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pll_run <= POWER_RST == POWER_RUN;
            pll_async_pd <= POWER_RST == POWER_ASYNC_PD;
            post_div_ratio <= ratio_of(POST_DIV_RST);
            div_bypass <= BYPASS_RST;
            src_vco <= SRC_VCO_RST;
            pfd_negative <= POLARITY_RST;
            abl_width <= ABL_RST;
        end else begin
            pll_run <= act_power_q == POWER_RUN;
            pll_async_pd <= act_power_q == POWER_ASYNC_PD;
            post_div_ratio <= ratio_of(act_div_q);
            div_bypass <= act_bypass_q;
            src_vco <= act_src_q;
            pfd_negative <= act_pol_q && !act_src_q;
            abl_width <= act_abl_q;
        end
    end

    // Calibration starts on a committed rise of the calibration bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vco_cal_start <= 1'h0;
        end else begin
            vco_cal_start <= commit && stg_cal_q && !act_cal_q;
        end
    end

    // Phase detector runs only while the loop is on
    assign pfd.enable = pll_run;
    assign pfd.invert = pfd_negative;
    assign pfd.abl_width = abl_width;

    phase_freq_detector u_pfd (
        .aclk(aclk),
        .aresetn(aresetn),
        .ref_div_in(ref_div_in),
        .fb_div_in(fb_div_in),
        .pfd(pfd)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cp_up <= 1'h0;
            cp_down <= 1'h0;
        end else begin
            cp_up <= pfd.up;
            cp_down <= pfd.down;
        end
    end

    // Read channel: one read at a time, answered the cycle after acceptance
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid <= 1'h0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid <= 1'h1;
            s_axi_rresp <= is_mapped(word_index(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
            case (word_index(s_axi_araddr))
                IDX_POWER_POL: s_axi_rdata <= {24'h0, stg_pol_q, 5'h0, stg_power_q};
                IDX_ANTIBACKLASH: s_axi_rdata <= {30'h0, stg_abl_q};
                IDX_VCO_CAL: s_axi_rdata <= {31'h0, stg_cal_q};
                IDX_POST_DIV: s_axi_rdata <= {29'h0, stg_div_q};
                IDX_ROUTING: s_axi_rdata <= {30'h0, stg_src_q, stg_bypass_q};
                IDX_STATUS: s_axi_rdata <= {19'h0, act_abl_q, act_pol_q, act_cal_q,
                    act_div_q, act_src_q, act_bypass_q, act_power_q, cp_down, cp_up};
                default: s_axi_rdata <= 32'h0;
            endcase
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'h0;
                s_axi_arready <= 1'h1;
            end
        end else begin
            s_axi_arready <= 1'h1;
        end
    end

    a_commit_power: assert property (@(posedge aclk) disable iff (!aresetn)
        commit |=> ##1 pll_async_pd == ($past(stg_power_q, 2) == POWER_ASYNC_PD))
        else $error("power state not applied after commit");

    a_power_run: assert property (@(posedge aclk) disable iff (!aresetn)
        pll_run |-> !pll_async_pd && $past(act_power_q) == POWER_RUN)
        else $error("run and power-down both shown");

    a_hold_active: assert property (@(posedge aclk) disable iff (!aresetn)
        !commit |=> $stable(act_div_q) && $stable(act_bypass_q) && $stable(act_src_q)
            && $stable(act_power_q) && $stable(act_cal_q) && $stable(act_pol_q)
            && $stable(act_abl_q))
        else $error("active copy changed without commit");

    a_bypass_route: assert property (@(posedge aclk) disable iff (!aresetn)
        commit |=> ##1 div_bypass == $past(stg_bypass_q, 2))
        else $error("bypass routing wrong after commit");

    a_source_select: assert property (@(posedge aclk) disable iff (!aresetn)
        commit |=> ##1 src_vco == $past(stg_src_q, 2))
        else $error("source select wrong after commit");

    a_ratio_map: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 (act_div_q == 3'h2) |=> post_div_ratio == 3'h4)
        else $error("code 010b does not give divide-by-4");

    a_cal_start: assert property (@(posedge aclk) disable iff (!aresetn)
        commit && stg_cal_q && !act_cal_q |=> vco_cal_start ##1 !vco_cal_start)
        else $error("calibration start pulse missing");

    a_no_recal: assert property (@(posedge aclk) disable iff (!aresetn)
        vco_cal_start |-> act_cal_q && !$past(act_cal_q))
        else $error("calibration started without a rise");

    a_pol_internal: assert property (@(posedge aclk) disable iff (!aresetn)
        src_vco |-> !pfd_negative)
        else $error("polarity applied with internal VCO");

    a_pump_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !pll_run [*3] |-> !cp_up && !cp_down)
        else $error("pump active while loop is off");

    a_abl_release: assert property (@(posedge aclk) disable iff (!aresetn)
        pll_run && cp_up && cp_down |-> ##[1:5] !(cp_up && cp_down))
        else $error("antibacklash overlap too long");
endmodule

// [verif/pll_clock_source_routing_tb.sv]
// Self-checking testbench for the PLL source routing control block
`timescale 1ns/1ps
module pll_clock_source_routing_tb
    import pll_route_pkg::*;
;
    // Staged register values beside the outputs expected after commit
    // exp = {run, async_pd, ratio[2:0], bypass, src_vco, negative, abl[1:0]}
    typedef struct packed {
        logic [7:0] pwr;
        logic [7:0] abl;
        logic [7:0] div;
        logic [7:0] rt;
        logic [9:0] exp;
    } row_t;

    logic aclk;
    logic aresetn;
    logic [11:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [11:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic ref_div_in;
    logic fb_div_in;
    logic pll_run;
    logic pll_async_pd;
    logic [2:0] post_div_ratio;
    logic div_bypass;
    logic src_vco;
    logic pfd_negative;
    logic [1:0] abl_width;
    logic vco_cal_start;
    logic cp_up;
    logic cp_down;
    logic [9:0] outs;
    logic [1:0] resp;
    logic [31:0] rd;
    int err_count = 0;
    int total_checks = 0;
    int cal_count = 0;
    row_t rows [8] = '{
        '{8'h01, 8'h00, 8'h02, 8'h00, 10'h180},
        '{8'h00, 8'h00, 8'h00, 8'h01, 10'h250},
        '{8'h81, 8'h01, 8'h01, 8'h01, 10'h175},
        '{8'h80, 8'h02, 8'h02, 8'h02, 10'h28a},
        '{8'h02, 8'h03, 8'h03, 8'h02, 10'h0ab},
        '{8'h03, 8'h00, 8'h04, 8'h00, 10'h0c0},
        '{8'h81, 8'h00, 8'h05, 8'h01, 10'h114},
        '{8'h00, 8'h00, 8'h02, 8'h00, 10'h280}
    };

    assign outs = {pll_run, pll_async_pd, post_div_ratio, div_bypass, src_vco, pfd_negative,
        abl_width};

    pll_clock_source_routing i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .ref_div_in(ref_div_in), .fb_div_in(fb_div_in),
        .pll_run(pll_run), .pll_async_pd(pll_async_pd), .post_div_ratio(post_div_ratio),
        .div_bypass(div_bypass), .src_vco(src_vco), .pfd_negative(pfd_negative),
        .abl_width(abl_width), .vco_cal_start(vco_cal_start), .cp_up(cp_up), .cp_down(cp_down)
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // One-cycle start pulses are counted here so none is missed
    always @(posedge aclk) begin
        if (vco_cal_start === 1'b1) begin
            cal_count <= cal_count + 1;
        end
    end

    function automatic logic [11:0] ba(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Released address and data lines show the inverse so stale values never look valid
    task automatic axi_write(input logic [11:0] addr, input logic [31:0] data);
        bit done;
        done = 1'b0;
        s_axi_awaddr <= addr;
        s_axi_wdata <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        resp = 2'h3;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~addr;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~data;
            end
            if (s_axi_bvalid === 1'b1) begin
                resp = s_axi_bresp;
                done = 1'b1;
            end
        end
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [11:0] addr);
        bit done;
        done = 1'b0;
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        resp = 2'h3;
        rd = 32'hdead_beef;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~addr;
            end
            if (s_axi_rvalid === 1'b1) begin
                resp = s_axi_rresp;
                rd = s_axi_rdata;
                done = 1'b1;
            end
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic commit();
        axi_write(ba(IDX_COMMIT), 32'h0000_0001);
    endtask

    task automatic edge_pin(input bit is_ref, input logic val);
        if (is_ref) begin
            ref_div_in <= val;
        end else begin
            fb_div_in <= val;
        end
        repeat (8) @(posedge aclk);
    endtask

    initial begin
        #400us;
        err_count++;
        end_sim();
    end

    initial begin
        aresetn = 1'b0;
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        ref_div_in = 1'b0;
        fb_div_in = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check(32'(outs), 32'(rows[0].exp));
        axi_read(ba(IDX_POST_DIV));
        check(rd, 32'(rows[0].div));
        for (int i = 1; i < 8; i++) begin
            axi_write(ba(IDX_POWER_POL), 32'(rows[i].pwr));
            axi_write(ba(IDX_ANTIBACKLASH), 32'(rows[i].abl));
            axi_write(ba(IDX_POST_DIV), 32'(rows[i].div));
            axi_write(ba(IDX_ROUTING), 32'(rows[i].rt));
            check(32'(resp), 32'(RESP_OKAY));
            axi_read(ba(IDX_POWER_POL));
            check(rd, 32'(rows[i].pwr));
            check(32'(outs), 32'(rows[i - 1].exp));
            commit();
            check(32'(outs), 32'(rows[i].exp));
        end
        // Active copies are visible in the status word: post-divider code 010b only
        axi_read(ba(IDX_STATUS));
        check(rd, 32'h0000_0080);
        // A commit value other than 0x01 must not apply staged settings
        axi_write(ba(IDX_POWER_POL), 32'h0000_0001);
        axi_write(ba(IDX_COMMIT), 32'h0000_0002);
        check(32'(pll_run), 32'h0000_0001);
        commit();
        check(32'(pll_async_pd), 32'h0000_0001);
        s_axi_wstrb <= 4'he;
        axi_write(ba(IDX_POWER_POL), 32'h0000_0000);
        s_axi_wstrb <= 4'hf;
        axi_read(ba(IDX_POWER_POL));
        check(rd, 32'h0000_0001);
        axi_write(ba(10'h000), 32'h0000_0001);
        check(32'(resp), 32'(RESP_SLVERR));
        axi_read(ba(10'h000));
        check(32'(resp), 32'(RESP_SLVERR));
        // Calibration: start, repeat without clearing, then clear and restart
        axi_write(ba(IDX_VCO_CAL), 32'h0000_0001);
        commit();
        check(cal_count, 1);
        commit();
        check(cal_count, 1);
        axi_write(ba(IDX_VCO_CAL), 32'h0000_0000);
        commit();
        axi_write(ba(IDX_VCO_CAL), 32'h0000_0001);
        commit();
        check(cal_count, 2);
        // Phase detector: run, external source, positive then negative sense
        axi_write(ba(IDX_POWER_POL), 32'h0000_0000);
        commit();
        edge_pin(1'b1, 1'b1);
        check(32'({cp_up, cp_down}), 32'h0000_0002);
        edge_pin(1'b0, 1'b1);
        check(32'({cp_up, cp_down}), 32'h0000_0000);
        edge_pin(1'b1, 1'b0);
        edge_pin(1'b0, 1'b0);
        axi_write(ba(IDX_POWER_POL), 32'h0000_0080);
        commit();
        edge_pin(1'b1, 1'b1);
        check(32'({cp_up, cp_down}), 32'h0000_0001);
        edge_pin(1'b0, 1'b1);
        check(32'({cp_up, cp_down}), 32'h0000_0000);
        // Reset in mid-run restores the power-up configuration
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check(32'(outs), 32'(rows[0].exp));
        axi_read(ba(IDX_POWER_POL));
        check(rd, 32'(POWER_RST));
        end_sim();
    end
endmodule
